// >>> bench/sbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_host (
	// clock
	input wire logic clk,
	// serial pins
	output logic serial_clk,
	output logic serial_data,
	output logic serial_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		serial_strobe = 1'b0;
	end
	// shifts n bits msb first at a 400 ns serial clock, then strobes
	task automatic send(input logic [18:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			serial_data = w[i];
			repeat (4) @(negedge clk);
			serial_clk = 1'b1;
			repeat (4) @(negedge clk);
			serial_clk = 1'b0;
		end
		serial_data = ~serial_data;
		serial_strobe = 1'b1;
		repeat (4) @(negedge clk);
		serial_strobe = 1'b0;
	endtask : send
endmodule : sbc_host
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sbc_pkg::*;
	logic clk = 1'b0, reset = 1'b1, sleep_n = 1'b1, sup_ok = 1'b1;
	wire sck, sda, stb;
	logic e1, a1, b1, s1, e2, a2, b2, s2, rx, rg, tv;
	sbc_dac_t d1, d2;
	logic [17:0] tw;
	logic [18:0] words [4] = '{19'h7_FFFE, 19'h2_A54C, 19'h5_5F80, 19'h0_007E};
	int miscompares = 0, comparisons = 0;
	always #25 clk = ~clk;
	sbc_top sbc_top_inst (.clk(clk), .reset(reset), .serial_clk(sck),
		.serial_data(sda), .serial_strobe(stb), .sleep_n(sleep_n),
		.logic_supply_ok(sup_ok), .bridge1_enable(e1),
		.bridge1_terminal_a(a1), .bridge1_terminal_b(b1), .bridge1_dac(d1),
		.bridge1_slow_decay(s1), .bridge2_enable(e2),
		.bridge2_terminal_a(a2), .bridge2_terminal_b(b2), .bridge2_dac(d2),
		.bridge2_slow_decay(s2), .reference_external(rx),
		.transconductance_range(rg), .timing_word(tw),
		.timing_word_valid(tv));
	sbc_host sbc_host_inst (.clk(clk), .serial_clk(sck), .serial_data(sda),
		.serial_strobe(stb));
	task automatic chk(input logic [18:0] got, input logic [18:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// decoded fields and bridge terminals against a control word
	task automatic ctl(input logic [18:0] w);
		logic x1, x2;
		x1 = |w[6:1];
		x2 = |w[12:7];
		chk({rg, rx, s2, s1, 2'b00, d2, d1}, w[18:1] & 18'h3_CFFF);
		chk({rg, rx}, w[18:17]);
		chk({e1, e2, a1, b1, a2, b2}, {x1, x2, x1 & w[13], x1 & ~w[13],
			x2 & w[14], x2 & ~w[14]});
	endtask : ctl
	task automatic load(input logic [18:0] w, input int n);
		sbc_host_inst.send(w, n);
		repeat (12) @(negedge clk);
	endtask : load
	task automatic close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	initial begin
		#1_000_000;
		miscompares++;
		close_out();
	end
	initial begin
		repeat (4) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		ctl(19'h0_0000);
		foreach (words[i]) begin
			load(words[i], 19);
			ctl(words[i]);
		end
		// timing word leaves control fields alone
		load(19'h4_0001, 19);
		chk({tv, tw}, 19'h6_0000);
		ctl(19'h0_007E);
		// short word is dropped
		load(19'h7_FFFE, 18);
		ctl(19'h0_007E);
		sleep_n = 1'b0;
		repeat (6) @(negedge clk);
		ctl(19'h0_0000);
		chk({tv, tw}, 19'h0_0000);
		sleep_n = 1'b1;
		repeat (3) @(negedge clk);
		load(19'h7_FFFE, 19);
		ctl(19'h7_FFFE);
		sup_ok = 1'b0;
		repeat (6) @(negedge clk);
		ctl(19'h0_0000);
		close_out();
	end
endmodule : tb
`default_nettype wire

// >>> logic/sbc_params.svh
// Overview of operation
// - three-wire port: serial clock, data and strobe, all driven by controller.
// - every transfer is nineteen bits; two words of that length exist.
// - one bit selects the word, the other eighteen carry its payload.
// - words shift most significant first, bit 18 down to select bit 0.
// - bits 1 to 6 are bridge one current code, bit 1 lsb.
// - bits 7 to 12 are bridge two current code, bit 7 lsb.
// - a zero current code disables that bridge with all drivers off.
// - bit 13 sets bridge one direction: 0 gives a low b high.
// - bit 14 sets bridge two direction: 0 gives a low b high.
// - bit 17 picks converter reference: 0 internal 2 V, 1 external.
// - bit 18 picks sense scaling: 0 divide by eight, 1 by four.
// - sleep input low clears every stored port bit and disables circuits.
// - power-up or low logic supply disables drivers and clears port data.
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH
`define SBC_WORD_BITS 19
`define SBC_PAYLOAD_BITS 18
`define SBC_SEL_POS 0
`define SBC_DAC1_LO 1
`define SBC_DAC1_HI 6
`define SBC_DAC2_LO 7
`define SBC_DAC2_HI 12
`define SBC_PHASE1_POS 13
`define SBC_PHASE2_POS 14
`define SBC_MODE1_POS 15
`define SBC_MODE2_POS 16
`define SBC_REF_POS 17
`define SBC_RANGE_POS 18
`define SBC_WORD_RESET 19'h0_0000
`define SBC_BITCNT_BITS 5
`endif

// >>> logic/sbc_pkg.sv
package sbc_pkg;
	typedef logic [18:0] sbc_word_t;
	typedef logic [5:0] sbc_dac_t;
	typedef logic [4:0] sbc_count_t;
endpackage : sbc_pkg

// >>> logic/sbc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_sync (
	// clock
	input wire logic clk,
	// asynchronous level in, synchronised level out
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;
	logic sync_q;
	always_ff @(posedge clk) begin
		meta_q <= async_in;
		sync_q <= meta_q;
	end
	assign sync_out = sync_q;
endmodule : sbc_sync
`default_nettype wire

// >>> logic/sbc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_params.svh"
module sbc_top
	import sbc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// serial port pins
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic serial_strobe,
	// supply and sleep pins
	input wire logic sleep_n,
	input wire logic logic_supply_ok,
	// bridge one
	output logic bridge1_enable,
	output logic bridge1_terminal_a,
	output logic bridge1_terminal_b,
	output sbc_dac_t bridge1_dac,
	output logic bridge1_slow_decay,
	// bridge two
	output logic bridge2_enable,
	output logic bridge2_terminal_a,
	output logic bridge2_terminal_b,
	output sbc_dac_t bridge2_dac,
	output logic bridge2_slow_decay,
	// shared settings
	output logic reference_external,
	output logic transconductance_range,
	// timing word payload
	output logic [17:0] timing_word,
	output logic timing_word_valid
);
	logic sclk_s, sdat_s, sstb_s, sleep_n_s, supply_ok_s;
	logic sclk_d1_q, sstb_d1_q;
	sbc_word_t shift_q, shift_d;
	sbc_count_t count_q, count_d;
	sbc_word_t ctrl_q, ctrl_d;
	logic [17:0] timing_q, timing_d;
	logic timing_valid_q, timing_valid_d;
	logic [1:0] drive1_q, drive2_q;
	logic enable1_q, enable2_q;

	sbc_sync u_sclk (.clk(clk), .async_in(serial_clk), .sync_out(sclk_s));
	sbc_sync u_sdat (.clk(clk), .async_in(serial_data), .sync_out(sdat_s));
	sbc_sync u_sstb (.clk(clk), .async_in(serial_strobe), .sync_out(sstb_s));
	sbc_sync u_slp (.clk(clk), .async_in(sleep_n), .sync_out(sleep_n_s));
	sbc_sync u_sup (.clk(clk), .async_in(logic_supply_ok),
		.sync_out(supply_ok_s));

	// clear sources: reset, sleep, low supply
	wire clear_all = reset | ~sleep_n_s | ~supply_ok_s;
	wire sclk_rise = sclk_s & ~sclk_d1_q;
	wire strobe_rise = sstb_s & ~sstb_d1_q;
	wire full_word = (count_q == 5'(`SBC_WORD_BITS));
	wire sel_timing = shift_q[`SBC_SEL_POS];
	wire load_ok = strobe_rise & full_word;

	// shift: first bit ends at position 18
	assign shift_d = sclk_rise ? {shift_q[17:0], sdat_s} : shift_q;
	assign count_d = strobe_rise ? 5'h0_0 :
		(sclk_rise & ~full_word) ? count_q + 5'h0_1 : count_q;
	assign ctrl_d = (load_ok & ~sel_timing) ? shift_q : ctrl_q;
	assign timing_d = (load_ok & sel_timing) ? shift_q[18:1] : timing_q;
	assign timing_valid_d = timing_valid_q | (load_ok & sel_timing);

	always_ff @(posedge clk) begin
		sclk_d1_q <= sclk_s;
		sstb_d1_q <= sstb_s;
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			shift_q <= `SBC_WORD_RESET;
			count_q <= 5'h0_0;
			ctrl_q <= `SBC_WORD_RESET;
			timing_q <= 18'h0_0000;
			timing_valid_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			count_q <= count_d;
			ctrl_q <= ctrl_d;
			timing_q <= timing_d;
			timing_valid_q <= timing_valid_d;
		end
	end

	// field decode
	function automatic logic [1:0] phase_drive(input logic en, input logic ph);
		phase_drive = en ? (ph ? 2'b10 : 2'b01) : 2'b00;
	endfunction : phase_drive

	wire sbc_dac_t dac1 = ctrl_q[`SBC_DAC1_HI:`SBC_DAC1_LO];
	wire sbc_dac_t dac2 = ctrl_q[`SBC_DAC2_HI:`SBC_DAC2_LO];
	wire en1 = (dac1 != 6'h00) & ~clear_all;
	wire en2 = (dac2 != 6'h00) & ~clear_all;
	wire [1:0] drive1 = phase_drive(en1, ctrl_q[`SBC_PHASE1_POS]);
	wire [1:0] drive2 = phase_drive(en2, ctrl_q[`SBC_PHASE2_POS]);

	always_ff @(posedge clk) begin
		if (reset) begin
			drive1_q <= 2'b00;
			drive2_q <= 2'b00;
			enable1_q <= 1'b0;
			enable2_q <= 1'b0;
		end else begin
			drive1_q <= drive1;
			drive2_q <= drive2;
			enable1_q <= en1;
			enable2_q <= en2;
		end
	end

	assign bridge1_enable = enable1_q;
	assign bridge2_enable = enable2_q;
	assign bridge1_terminal_a = drive1_q[1];
	assign bridge1_terminal_b = drive1_q[0];
	assign bridge2_terminal_a = drive2_q[1];
	assign bridge2_terminal_b = drive2_q[0];
	assign bridge1_dac = dac1;
	assign bridge2_dac = dac2;
	assign bridge1_slow_decay = ctrl_q[`SBC_MODE1_POS];
	assign bridge2_slow_decay = ctrl_q[`SBC_MODE2_POS];
	assign reference_external = ctrl_q[`SBC_REF_POS];
	assign transconductance_range = ctrl_q[`SBC_RANGE_POS];
	assign timing_word = timing_q;
	assign timing_word_valid = timing_valid_q;

	a_zero_code_off: assert property (@(posedge clk) disable iff (reset)
		(dac1 == 6'h00) |=> !bridge1_terminal_a && !bridge1_terminal_b)
		else $error("bridge one driven with zero code");
	a_phase_one: assert property (@(posedge clk) disable iff (reset)
		en1 |=> bridge1_terminal_a == $past(ctrl_q[13]) &&
		bridge1_terminal_b != $past(ctrl_q[13]))
		else $error("bridge one direction wrong");
	a_phase_two: assert property (@(posedge clk) disable iff (reset)
		en2 |=> bridge2_terminal_a == $past(ctrl_q[14]) &&
		bridge2_terminal_b != $past(ctrl_q[14]))
		else $error("bridge two direction wrong");
	a_sleep_clears: assert property (@(posedge clk) disable iff (reset)
		!sleep_n_s |=> ctrl_q == 19'h0_0000 && !timing_word_valid)
		else $error("sleep did not clear port");
	a_supply_clears: assert property (@(posedge clk) disable iff (reset)
		!supply_ok_s |=> ctrl_q == 19'h0_0000 && !bridge1_enable)
		else $error("low supply did not clear port");
	a_load_ctrl: assert property (@(posedge clk) disable iff (reset)
		load_ok && !sel_timing && !clear_all |=> ctrl_q == $past(shift_q))
		else $error("control word not loaded");
	a_load_timing: assert property (@(posedge clk) disable iff (reset)
		load_ok && sel_timing && !clear_all |=>
		ctrl_q == $past(ctrl_q) && timing_word_valid)
		else $error("timing word load touched control");
	a_short_ignored: assert property (@(posedge clk) disable iff (reset)
		strobe_rise && !full_word && !clear_all |=>
		ctrl_q == $past(ctrl_q))
		else $error("short word was loaded");
	a_shift_order: assert property (@(posedge clk) disable iff (reset)
		sclk_rise && !clear_all |=> shift_q[0] == $past(sdat_s) &&
		shift_q[18:1] == $past(shift_q[17:0]))
		else $error("shift order wrong");

	// bit counting
	a_count_capped: assert property (@(posedge clk) disable iff (reset)
		count_q <= 5'(`SBC_WORD_BITS))
		else $error("bit count ran past word length");
	a_strobe_restarts: assert property (@(posedge clk) disable iff (reset)
		strobe_rise |=> count_q == 5'h0_0)
		else $error("strobe did not restart bit count");
	a_count_steps: assert property (@(posedge clk) disable iff (reset)
		sclk_rise && !strobe_rise && !full_word && !clear_all |=>
		count_q == $past(count_q) + 5'h0_1)
		else $error("bit count did not advance");

	// bridge enables and zero codes
	a_zero_code_two: assert property (@(posedge clk) disable iff (reset)
		(dac2 == 6'h00) |=> !bridge2_terminal_a && !bridge2_terminal_b)
		else $error("bridge two driven with zero code");
	a_enable_one: assert property (@(posedge clk) disable iff (reset)
		!clear_all |=> bridge1_enable == ($past(dac1) != 6'h00))
		else $error("bridge one enable wrong");
	a_enable_two: assert property (@(posedge clk) disable iff (reset)
		!clear_all |=> bridge2_enable == ($past(dac2) != 6'h00))
		else $error("bridge two enable wrong");

	// clearing conditions turn drivers off
	a_sleep_off: assert property (@(posedge clk) disable iff (reset)
		!sleep_n_s |=> !bridge1_terminal_a && !bridge1_terminal_b &&
		!bridge2_terminal_a && !bridge2_terminal_b)
		else $error("sleep left a driver on");
	a_supply_off: assert property (@(posedge clk) disable iff (reset)
		!supply_ok_s |=> !bridge2_enable && timing_word == 18'h0_0000)
		else $error("low supply left bridge two or timing set");

	// word routing by select bit
	a_timing_kept: assert property (@(posedge clk) disable iff (reset)
		load_ok && !sel_timing && !clear_all |=>
		timing_word == $past(timing_word))
		else $error("control load touched timing word");
	a_timing_payload: assert property (@(posedge clk) disable iff (reset)
		load_ok && sel_timing && !clear_all |=>
		timing_word == $past(shift_q[18:1]))
		else $error("timing payload not loaded");
endmodule : sbc_top
`default_nettype wire
